// ==== nvsrc_pkg.sv ====
// Constants, types and sequence addresses for the store/recall memory host.
// Assumes a 200 MHz host clock; all times become cycle counts here.
package nvsrc_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;
    localparam int CNT_W = 22;
    localparam int SEQ_LEN = 6;

    // ------------------------------------------------------------
    // Timing, in ns as printed, then cycles
    // ------------------------------------------------------------
    localparam int CLK_NS = 5;
    localparam int T_ACC_NS = 45;
    localparam int T_WPULSE_NS = 30;
    localparam int T_HSB_PULSE_NS = 15;
    localparam int T_HSB_BUSY_NS = 300;
    localparam int T_RECOVER_NS = 100;
    localparam int T_RECALL_NS = 20000;
    localparam int T_STORE_NS = 10000000;
    localparam int T_RESTORE_NS = 5000000;
    localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int WPULSE_CYC = (T_WPULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int HSB_PULSE_CYC = (T_HSB_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int HSB_BUSY_CYC = T_HSB_BUSY_NS / CLK_NS;
    localparam int RECOVER_CYC = (T_RECOVER_NS + CLK_NS - 1) / CLK_NS;
    localparam int RECALL_CYC = T_RECALL_NS / CLK_NS;
    localparam int STORE_CYC = T_STORE_NS / CLK_NS;
    localparam int RESTORE_CYC = T_RESTORE_NS / CLK_NS;

    // ------------------------------------------------------------
    // Trigger sequence addresses
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] SEQ_A0 = 17'h04E38;
    localparam logic [ADDR_W-1:0] SEQ_A1 = 17'h0B1C7;
    localparam logic [ADDR_W-1:0] SEQ_A2 = 17'h083E0;
    localparam logic [ADDR_W-1:0] SEQ_A3 = 17'h07C1F;
    localparam logic [ADDR_W-1:0] SEQ_A4 = 17'h0703F;
    localparam logic [ADDR_W-1:0] SEQ_STORE = 17'h08FC0;
    localparam logic [ADDR_W-1:0] SEQ_RECALL = 17'h04C63;
    localparam logic [ADDR_W-1:0] SEQ_INH_ON = 17'h08B45;
    localparam logic [ADDR_W-1:0] SEQ_INH_OFF = 17'h04B46;

    typedef enum logic [2:0] {
        CMD_READ,
        CMD_WRITE,
        CMD_SW_STORE,
        CMD_SW_RECALL,
        CMD_INH_ON,
        CMD_INH_OFF,
        CMD_HW_STORE
    } nvsrc_cmd_t;

    typedef struct packed {
        nvsrc_cmd_t cmd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } nvsrc_req_t;

endpackage

// ==== nvsrc_host.sv ====
// Host controller that drives a byte-wide store/recall static memory.
// Assumes the memory pins sit outside this clock; all pin inputs are synchronised.
// Operation
// - Store sequence ends with address 8FC0.
// - Recall sequence ends with address 4C63.
// - Write strobe stays high during sequences.
// - Address stable through write, data at rise.
// - Store request pulse at least 15 ns.
`timescale 1ns/10ps
module nvsrc_host
    import nvsrc_pkg::*;
#(
    parameter int STORE_CYCLES = STORE_CYC,
    parameter int RESTORE_CYCLES = RESTORE_CYC
) (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic power_ok_in,
    input wire logic req_valid_in,
    input wire nvsrc_req_t req_in,
    output logic req_ready_out,
    output logic rsp_valid_out,
    output logic [DATA_W-1:0] rsp_data_out,
    output logic busy_out,
    output logic cs_n_out,
    output logic out_drv_n_out,
    output logic data_in_strobe_n_out,
    output logic [ADDR_W-1:0] addr_out,
    input wire logic [DATA_W-1:0] dq_in,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe_out,
    input wire logic store_busy_n_in,
    output logic store_busy_n_out,
    output logic store_busy_n_oe_out
);

    typedef enum logic [3:0] {
        ST_RSTR, ST_IDLE, ST_RD, ST_RD_GAP, ST_WR_SET, ST_WR, ST_WR_END,
        ST_NV, ST_HS_PULL, ST_HS_WAIT, ST_BUSY, ST_RECOV
    } nvsrc_state_t;

    localparam logic [CNT_W-1:0] ACC_C = CNT_W'(ACC_CYC + 2);
    localparam logic [CNT_W-1:0] WPULSE_C = CNT_W'(WPULSE_CYC);
    localparam logic [CNT_W-1:0] HSB_PULSE_C = CNT_W'(HSB_PULSE_CYC);
    localparam logic [CNT_W-1:0] HSB_BUSY_C = CNT_W'(HSB_BUSY_CYC + 2);
    localparam logic [CNT_W-1:0] RECOVER_C = CNT_W'(RECOVER_CYC);
    localparam logic [CNT_W-1:0] RECALL_C = CNT_W'(RECALL_CYC);
    localparam logic [CNT_W-1:0] STORE_C = CNT_W'(STORE_CYCLES);
    localparam logic [CNT_W-1:0] RESTORE_C = CNT_W'(RESTORE_CYCLES);

    nvsrc_state_t state_ff;
    nvsrc_req_t req_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [2:0] seq_idx_ff;
    logic [DATA_W-1:0] dq_meta_ff, dq_sync_ff;
    logic hsb_meta_ff, hsb_sync_ff, pok_meta_ff, pok_sync_ff, pok_prev_ff;
    logic cs_n_ff, oe_n_ff, we_n_ff, dq_oe_ff, hsb_oe_ff, rsp_valid_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [DATA_W-1:0] dq_ff, rsp_data_ff;
    logic is_seq;
    logic [ADDR_W-1:0] seq_addr;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            dq_meta_ff <= '0;
            dq_sync_ff <= '0;
            hsb_meta_ff <= 1'b1;
            hsb_sync_ff <= 1'b1;
            pok_meta_ff <= 1'b0;
            pok_sync_ff <= 1'b0;
            pok_prev_ff <= 1'b0;
        end else begin
            dq_meta_ff <= dq_in;
            dq_sync_ff <= dq_meta_ff;
            hsb_meta_ff <= store_busy_n_in;
            hsb_sync_ff <= hsb_meta_ff;
            pok_meta_ff <= power_ok_in;
            pok_sync_ff <= pok_meta_ff;
            pok_prev_ff <= pok_sync_ff;
        end
    end

    // ------------------------------------------------------------
    // Sequence address select
    // ------------------------------------------------------------
    always_comb begin
        is_seq = (req_ff.cmd == CMD_SW_STORE) || (req_ff.cmd == CMD_SW_RECALL) ||
                 (req_ff.cmd == CMD_INH_ON) || (req_ff.cmd == CMD_INH_OFF);
        // Address of the frame that follows frame seq_idx_ff
        case (seq_idx_ff)
            3'h0: seq_addr = SEQ_A1;
            3'h1: seq_addr = SEQ_A2;
            3'h2: seq_addr = SEQ_A3;
            3'h3: seq_addr = SEQ_A4;
            default: begin
                case (req_ff.cmd)
                    CMD_SW_STORE: seq_addr = SEQ_STORE;
                    CMD_SW_RECALL: seq_addr = SEQ_RECALL;
                    CMD_INH_ON: seq_addr = SEQ_INH_ON;
                    default: seq_addr = SEQ_INH_OFF;
                endcase
            end
        endcase
    end

    // ------------------------------------------------------------
    // Access sequencer and pin drive
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_ff <= ST_RSTR;
            req_ff <= '0;
            cnt_ff <= RESTORE_C;
            seq_idx_ff <= 3'h0;
            cs_n_ff <= 1'b1;
            oe_n_ff <= 1'b1;
            we_n_ff <= 1'b1;
            addr_ff <= '0;
            dq_ff <= '0;
            dq_oe_ff <= 1'b0;
            hsb_oe_ff <= 1'b0;
        end else if (!pok_sync_ff) begin
            // Supply down: park all strobes, re-arm restore wait
            state_ff <= ST_RSTR;
            cnt_ff <= RESTORE_C;
            cs_n_ff <= 1'b1;
            oe_n_ff <= 1'b1;
            we_n_ff <= 1'b1;
            dq_oe_ff <= 1'b0;
            hsb_oe_ff <= 1'b0;
        end else begin
            case (state_ff)
                ST_RSTR: begin
                    // Restore counted from power rise
                    if (pok_sync_ff && !pok_prev_ff) begin
                        cnt_ff <= RESTORE_C;
                    end else if (cnt_ff != '0) begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end else begin
                        state_ff <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (!hsb_sync_ff) begin
                        // Foreign busy is no command, so no answer follows
                        req_ff <= '0;
                        state_ff <= ST_BUSY;
                    end else if (req_valid_in) begin
                        req_ff <= req_in;
                        seq_idx_ff <= 3'h0;
                        case (req_in.cmd)
                            CMD_READ: begin
                                addr_ff <= req_in.addr;
                                cs_n_ff <= 1'b0;
                                oe_n_ff <= 1'b0;
                                cnt_ff <= ACC_C;
                                state_ff <= ST_RD;
                            end
                            CMD_WRITE: begin
                                addr_ff <= req_in.addr;
                                dq_ff <= req_in.data;
                                oe_n_ff <= 1'b1;
                                cs_n_ff <= 1'b0;
                                state_ff <= ST_WR_SET;
                            end
                            CMD_HW_STORE: begin
                                hsb_oe_ff <= 1'b1;
                                cnt_ff <= HSB_PULSE_C;
                                state_ff <= ST_HS_PULL;
                            end
                            default: begin
                                // Trigger reads, chip select framed
                                addr_ff <= SEQ_A0;
                                cs_n_ff <= 1'b0;
                                oe_n_ff <= 1'b0;
                                cnt_ff <= ACC_C;
                                state_ff <= ST_RD;
                            end
                        endcase
                    end
                end
                ST_RD: begin
                    if (cnt_ff != '0) begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end else begin
                        cs_n_ff <= 1'b1;
                        oe_n_ff <= 1'b1;
                        state_ff <= ST_RD_GAP;
                    end
                end
                ST_RD_GAP: begin
                    if (is_seq && seq_idx_ff != 3'(SEQ_LEN - 1)) begin
                        // Back to back, nothing else admitted
                        seq_idx_ff <= seq_idx_ff + 3'h1;
                        addr_ff <= seq_addr;
                        cs_n_ff <= 1'b0;
                        oe_n_ff <= 1'b0;
                        cnt_ff <= ACC_C;
                        state_ff <= ST_RD;
                    end else if (req_ff.cmd == CMD_SW_STORE) begin
                        cnt_ff <= STORE_C;
                        state_ff <= ST_NV;
                    end else if (req_ff.cmd == CMD_SW_RECALL) begin
                        cnt_ff <= RECALL_C;
                        state_ff <= ST_NV;
                    end else begin
                        state_ff <= ST_IDLE;
                    end
                end
                ST_WR_SET: begin
                    we_n_ff <= 1'b0;
                    dq_oe_ff <= 1'b1;
                    cnt_ff <= WPULSE_C;
                    state_ff <= ST_WR;
                end
                ST_WR: begin
                    if (cnt_ff != '0) begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end else begin
                        we_n_ff <= 1'b1;
                        state_ff <= ST_WR_END;
                    end
                end
                ST_WR_END: begin
                    cs_n_ff <= 1'b1;
                    dq_oe_ff <= 1'b0;
                    state_ff <= ST_IDLE;
                end
                ST_NV: begin
                    // Wait out the cycle and any busy hold
                    if (cnt_ff != '0) begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end else if (hsb_sync_ff) begin
                        cnt_ff <= RECOVER_C;
                        state_ff <= ST_RECOV;
                    end
                end
                ST_HS_PULL: begin
                    if (cnt_ff != '0) begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end else begin
                        hsb_oe_ff <= 1'b0;
                        cnt_ff <= HSB_BUSY_C;
                        state_ff <= ST_HS_WAIT;
                    end
                end
                ST_HS_WAIT: begin
                    // No busy answer means store skipped
                    if (!hsb_sync_ff) begin
                        state_ff <= ST_BUSY;
                    end else if (cnt_ff != '0) begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end else begin
                        state_ff <= ST_IDLE;
                    end
                end
                ST_BUSY: begin
                    if (hsb_sync_ff) begin
                        cnt_ff <= RECOVER_C;
                        state_ff <= ST_RECOV;
                    end
                end
                ST_RECOV: begin
                    if (cnt_ff != '0) begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end else begin
                        state_ff <= ST_IDLE;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Answers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rsp_valid_ff <= 1'b0;
            rsp_data_ff <= '0;
        end else begin
            rsp_valid_ff <= 1'b0;
            if (state_ff == ST_RD && cnt_ff == '0 && !is_seq) begin
                rsp_data_ff <= dq_sync_ff;
                rsp_valid_ff <= 1'b1;
            end else if (state_ff == ST_WR_END) begin
                rsp_valid_ff <= 1'b1;
            end else if (state_ff == ST_RD_GAP && is_seq && seq_idx_ff == 3'(SEQ_LEN - 1)
                         && (req_ff.cmd == CMD_INH_ON || req_ff.cmd == CMD_INH_OFF)) begin
                rsp_valid_ff <= 1'b1;
            end else if (state_ff == ST_RECOV && cnt_ff == '0 && req_ff.cmd != CMD_READ
                         && req_ff.cmd != CMD_WRITE) begin
                rsp_valid_ff <= 1'b1;
            end else if (state_ff == ST_HS_WAIT && hsb_sync_ff && cnt_ff == '0) begin
                rsp_valid_ff <= 1'b1;
            end
        end
    end

    assign req_ready_out = (state_ff == ST_IDLE) && hsb_sync_ff && pok_sync_ff;
    assign busy_out = (state_ff != ST_IDLE);
    assign rsp_valid_out = rsp_valid_ff;
    assign rsp_data_out = rsp_data_ff;
    assign cs_n_out = cs_n_ff;
    assign out_drv_n_out = oe_n_ff;
    assign data_in_strobe_n_out = we_n_ff;
    assign addr_out = addr_ff;
    assign dq_out = dq_ff;
    assign dq_oe_out = dq_oe_ff;
    assign store_busy_n_out = 1'b0;
    assign store_busy_n_oe_out = hsb_oe_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_pull_hold;
        store_busy_n_oe_out [*4];
    endsequence

    property p_seq_we_high;
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        (is_seq && state_ff == ST_RD) |-> we_n_ff && !cs_n_ff;
    endproperty
    a_seq_we_high: assert property (p_seq_we_high) else $error("write strobe low in sequence");

    property p_rd_strobes;
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        (state_ff == ST_RD) |-> (!cs_n_ff && !oe_n_ff && we_n_ff);
    endproperty
    a_rd_strobes: assert property (p_rd_strobes) else $error("read strobes wrong");

    property p_wr_oe_high;
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        !we_n_ff |-> oe_n_ff && dq_oe_ff;
    endproperty
    a_wr_oe_high: assert property (p_wr_oe_high) else $error("output enable low in write");

    property p_wr_addr_stable;
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        ($past(we_n_ff) == 1'b0) |-> $stable(addr_ff) && !cs_n_ff;
    endproperty
    a_wr_addr_stable: assert property (p_wr_addr_stable) else $error("address moved in write");

    property p_no_access_busy;
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        $fell(cs_n_ff) && $past(state_ff) == ST_IDLE |-> $past(hsb_sync_ff);
    endproperty
    a_no_access_busy: assert property (p_no_access_busy) else $error("access while busy low");

    property p_hsb_pulse;
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        $rose(store_busy_n_oe_out) |-> s_pull_hold ##1 !store_busy_n_oe_out;
    endproperty
    a_hsb_pulse: assert property (p_hsb_pulse) else $error("store request pulse width");

    property p_nv_quiet;
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        (state_ff == ST_NV || state_ff == ST_BUSY) |-> cs_n_ff && we_n_ff;
    endproperty
    a_nv_quiet: assert property (p_nv_quiet) else $error("access during store or recall");

    property p_recover;
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        (state_ff == ST_BUSY && hsb_sync_ff && pok_sync_ff) |=> cs_n_ff [*8];
    endproperty
    a_recover: assert property (p_recover) else $error("recovery time too short");

    property p_restore;
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        $rose(pok_sync_ff) |-> cs_n_ff [*8];
    endproperty
    a_restore: assert property (p_restore) else $error("access before restore");

endmodule

// ==== nvsrc_mem_model.sv ====
// Behavioural store/recall static memory on the far side of the host.
// Assumes active-low host strobes and a pulled-up shared busy line.
`timescale 1ns/10ps
module nvsrc_mem_model
    import nvsrc_pkg::*;
#(
    parameter int STORE_NS = 200,
    parameter int RECALL_NS = 100
) (
    input wire logic cs_n_in,
    input wire logic out_drv_n_in,
    input wire logic we_n_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] host_dq_in,
    input wire logic host_oe_in,
    input wire logic host_pull_in,
    input wire logic ext_pull_in,
    input wire logic power_ok_in,
    output logic [DATA_W-1:0] dq_out,
    output logic busy_line_out,
    output logic [7:0] stores_out = 8'h00,
    output logic [7:0] recalls_out = 8'h00,
    output logic inhibit_out = 1'b0
);
    // ----------------------------------------
    // Array, shadow copy and mode
    // ----------------------------------------
    localparam logic [ADDR_W-1:0] SQ [5] = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
    logic [7:0] mem [int];
    logic [7:0] nvm [int];
    logic nv = 1'b0;
    logic pull = 1'b0;
    logic written = 1'b0;
    logic wrf = 1'b0;
    logic wr_ok = 1'b0;
    logic drv;
    int idx = 0;
    function automatic logic [7:0] rd(input logic [16:0] a);
        return mem.exists(a) ? mem[a] : 8'h00;
    endfunction
    task automatic run_store();
        nv = 1'b1;
        pull = 1'b1;
        #STORE_NS;
        nvm = mem;
        written = 1'b0;
        stores_out++;
        pull = 1'b0;
        nv = 1'b0;
    endtask
    task automatic run_recall();
        nv = 1'b1;
        #RECALL_NS;
        mem = nvm;
        written = 1'b0;
        recalls_out++;
        nv = 1'b0;
    endtask
    assign busy_line_out = !(host_pull_in || pull || ext_pull_in);
    assign drv = !cs_n_in && !out_drv_n_in && we_n_in && busy_line_out && !nv;
    assign dq_out = host_oe_in ? host_dq_in : (drv ? rd(addr_in) : ~rd(addr_in));
    // Strobe already low when a cycle ends must rise and fall again
    always @(negedge we_n_in) begin
        wrf = 1'b1;
        wr_ok = !nv;
    end
    always @(posedge we_n_in) begin
        if (!cs_n_in && !nv && busy_line_out && wr_ok) begin
            mem[addr_in] = host_dq_in;
            written = 1'b1;
        end
    end
    always @(posedge cs_n_in) begin
        if (wrf || nv) begin
            idx = 0;
            wrf = 1'b0;
        end else if (idx == 5) begin
            idx = 0;
            case (addr_in[15:0])
                SEQ_STORE[15:0]: run_store();
                SEQ_RECALL[15:0]: run_recall();
                SEQ_INH_ON[15:0]: inhibit_out = 1'b1;
                SEQ_INH_OFF[15:0]: inhibit_out = 1'b0;
                default: ;
            endcase
        end else begin
            idx = (addr_in[15:0] == SQ[idx][15:0]) ? idx + 1 : 0;
        end
    end
    always @(negedge busy_line_out) begin
        if (!nv && written) begin
            #5;
            pull = 1'b1;
            #1000;
            run_store();
        end
    end
    always @(negedge power_ok_in) begin
        if (written && !inhibit_out && !nv) run_store();
    end
    always @(posedge power_ok_in) run_recall();
endmodule

// ==== testbench.sv ====
// Self-checking bench for the store/recall host against the memory model.
// Assumes nvsrc_pkg, nvsrc_host and nvsrc_mem_model compile first.
`timescale 1ns/10ps
module testbench;
    import nvsrc_pkg::*;
    typedef struct packed {
        logic chk;
        logic [7:0] d;
    } nvsrc_note_t;
    logic ref_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic power_ok_in = 1'b1;
    logic req_valid_in = 1'b0;
    logic ext_pull = 1'b0;
    nvsrc_req_t req_in = '0;
    logic req_ready_out, rsp_valid_out, busy_out, cs_n, oe_n, we_n, dq_oe, pull, line, inh;
    logic [7:0] rsp_data_out, dq_h, dq_m, stores, recalls, s0, r0;
    logic [16:0] addr;
    logic [16:0] wa [8];
    logic [7:0] wd [8];
    int n_errors = 0;
    int comparisons = 0;
    int n_rsp = 0;
    nvsrc_note_t notes[$];
    nvsrc_note_t nt;
    nvsrc_host #(.STORE_CYCLES(50), .RESTORE_CYCLES(30)) dut_u (
        .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .power_ok_in(power_ok_in),
        .req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out),
        .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out), .busy_out(busy_out),
        .cs_n_out(cs_n), .out_drv_n_out(oe_n), .data_in_strobe_n_out(we_n), .addr_out(addr),
        .dq_in(dq_m), .dq_out(dq_h), .dq_oe_out(dq_oe), .store_busy_n_in(line),
        .store_busy_n_out(), .store_busy_n_oe_out(pull));
    nvsrc_mem_model mem_u (
        .cs_n_in(cs_n), .out_drv_n_in(oe_n), .we_n_in(we_n), .addr_in(addr), .host_dq_in(dq_h),
        .host_oe_in(dq_oe), .host_pull_in(pull), .ext_pull_in(ext_pull),
        .power_ok_in(power_ok_in), .dq_out(dq_m), .busy_line_out(line),
        .stores_out(stores), .recalls_out(recalls), .inhibit_out(inh));
    // ----------------------------------------
    // Clock, compares and request driver
    // ----------------------------------------
    initial begin
        forever #2.5 ref_clk_in = ~ref_clk_in;
    end
    task automatic cmp_data(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t read data %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_stat(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t %s is %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic final_report();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic do_req(input nvsrc_cmd_t c, input logic [16:0] a, input logic [7:0] d,
                          input logic chk);
        int i;
        int start;
        start = n_rsp;
        notes.push_back('{chk, d});
        req_in = '{c, a, d};
        req_valid_in = 1'b1;
        i = 0;
        do begin
            @(posedge ref_clk_in);
            i++;
        end while (req_ready_out !== 1'b1 && i < 5000);
        #1;
        req_valid_in = 1'b0;
        while (n_rsp == start && i < 5000) begin
            @(posedge ref_clk_in);
            #1;
            i++;
        end
        if (i >= 5000) begin
            n_errors++;
            $display("[ERR] %0t wait ran out", $time);
            final_report();
        end
    endtask
    always @(posedge ref_clk_in) begin
        if (rsp_valid_out === 1'b1) begin
            n_rsp++;
            if (notes.size() == 0) begin
                cmp_stat(8'h01, 8'h00, "unexpected answer");
            end else begin
                nt = notes.pop_front();
                if (nt.chk) cmp_data(rsp_data_out, nt.d);
            end
        end
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        void'($urandom(32'he09c));
        repeat (6) @(posedge ref_clk_in);
        #1;
        rst_b_in = 1'b1;
        for (int i = 0; i < 8; i++) begin
            wa[i] = 17'($urandom());
            wa[i][3:0] = i[3:0];
            wd[i] = 8'($urandom());
            do_req(CMD_WRITE, wa[i], wd[i], 1'b0);
        end
        for (int i = 0; i < 8; i++) do_req(CMD_READ, wa[i], wd[i], 1'b1);
        s0 = stores;
        do_req(CMD_HW_STORE, 17'h00000, 8'h00, 1'b0);
        cmp_stat(stores, s0 + 8'h01, "pin store");
        do_req(CMD_HW_STORE, 17'h00000, 8'h00, 1'b0);
        cmp_stat(stores, s0 + 8'h01, "skipped store");
        do_req(CMD_SW_STORE, 17'h00000, 8'h00, 1'b0);
        cmp_stat(stores, s0 + 8'h02, "soft store");
        do_req(CMD_WRITE, wa[0], ~wd[0], 1'b0);
        r0 = recalls;
        do_req(CMD_SW_RECALL, 17'h00000, 8'h00, 1'b0);
        cmp_stat(recalls, r0 + 8'h01, "soft recall");
        do_req(CMD_READ, wa[0], wd[0], 1'b1);
        do_req(CMD_INH_ON, 17'h00000, 8'h00, 1'b0);
        cmp_stat({7'h00, inh}, 8'h01, "inhibit set");
        do_req(CMD_INH_OFF, 17'h00000, 8'h00, 1'b0);
        cmp_stat({7'h00, inh}, 8'h00, "inhibit clear");
        ext_pull = 1'b1;
        repeat (10) @(posedge ref_clk_in);
        #1;
        cmp_stat({6'h00, busy_out, req_ready_out}, 8'h02, "foreign busy");
        ext_pull = 1'b0;
        do_req(CMD_WRITE, wa[1], ~wd[1], 1'b0);
        s0 = stores;
        r0 = recalls;
        power_ok_in = 1'b0;
        repeat (80) @(posedge ref_clk_in);
        #1;
        power_ok_in = 1'b1;
        repeat (4) @(posedge ref_clk_in);
        #1;
        cmp_stat({7'h00, req_ready_out}, 8'h00, "restore wait");
        do_req(CMD_READ, wa[1], ~wd[1], 1'b1);
        cmp_stat(stores, s0 + 8'h01, "power store");
        cmp_stat(recalls, r0 + 8'h01, "power recall");
        final_report();
    end
endmodule
